// [logic/lecr_regs.sv]
/*
 * Lookup engine control registers: forwarding map filter, priority choice,
 * flush scope and aging period. Assumes synchronous inputs on clk_sys_in and
 * a lookup result presented as one struct per cycle.
 */
`default_nettype none

module lecr_regs #(
   parameter int SEC_CYCLES = lecr_pkg::SEC_CYCLES
) (
   input  wire logic                  clk_sys_in,
   input  wire logic                  rst_n_in,
   input  wire logic [15:0]           reg_addr_in,
   input  wire logic [7:0]            reg_wdata_in,
   input  wire logic                  reg_wr_in,
   input  wire logic                  reg_rd_in,
   output logic [7:0]                 reg_rdata_out,
   input  wire logic                  double_tag_en_in,
   input  wire lecr_pkg::lecr_lookup_t lookup_in,
   output lecr_pkg::lecr_fwd_t        fwd_out,
   output logic                       flush_dyn_out,
   output logic                       flush_static_out,
   output logic                       flush_mstp_out,
   output logic                       age_step_out,
   output logic [7:0]                 age_period_out
);

   // ************************************************************
   // Register decode
   // ************************************************************
   wire wr_one = reg_wr_in && (reg_addr_in == lecr_pkg::ADDR_CTRL_ONE);
   wire wr_two = reg_wr_in && (reg_addr_in == lecr_pkg::ADDR_CTRL_TWO);
   wire wr_age = reg_wr_in && (reg_addr_in == lecr_pkg::ADDR_AGE_BASE);

   logic [7:0]  ctrl_two_q;
   logic [7:0]  age_base_q;
   logic        age_en_q;
   logic        flush_all_q;
   logic        flush_mstp_q;
   logic [7:0]  reg_rdata_q;
   logic [25:0] tick_cnt_q;
   logic [7:0]  sec_cnt_q;
   logic        age_step_q;
   logic        flush_dyn_q;
   logic        flush_stat_q;
   logic        flush_mstp_out_q;
   lecr_pkg::lecr_fwd_t fwd_q;

   wire [1:0] flush_sel = ctrl_two_q[lecr_pkg::FLUSH_SEL_HI:lecr_pkg::FLUSH_SEL_LO];
   wire [1:0] prio_sel  = ctrl_two_q[lecr_pkg::PRIO_SEL_HI:lecr_pkg::PRIO_SEL_LO];

   // Bits of the neighbouring register that this block does not own read zero
   wire [7:0] ctrl_one_rd = {2'h0, flush_all_q, flush_mstp_q, 1'b0, age_en_q, 2'h0};

   wire [7:0] rdata_d = (reg_addr_in == lecr_pkg::ADDR_CTRL_ONE) ? ctrl_one_rd :
                        (reg_addr_in == lecr_pkg::ADDR_CTRL_TWO) ? ctrl_two_q  :
                        (reg_addr_in == lecr_pkg::ADDR_AGE_BASE) ? age_base_q  : 8'h00;

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ctrl_two_q  <= lecr_pkg::RST_CTRL_TWO;
         age_base_q  <= lecr_pkg::RST_AGE_BASE;
         age_en_q    <= lecr_pkg::RST_AGE_EN;
         reg_rdata_q <= 8'h00;
      end else begin
         if (wr_two) begin
            ctrl_two_q <= reg_wdata_in;
         end
         if (wr_age) begin
            age_base_q <= reg_wdata_in;
         end
         if (wr_one) begin
            age_en_q <= reg_wdata_in[lecr_pkg::BIT_AGE_EN];
         end
         if (reg_rd_in) begin
            reg_rdata_q <= rdata_d;
         end
      end
   end

   assign reg_rdata_out  = reg_rdata_q;
   assign age_period_out = age_base_q;

   // ************************************************************
   // Flush start
   // ************************************************************
   // Trigger bits hold for one cycle only, so a flush never restarts by itself
   wire flush_go = flush_all_q || flush_mstp_q;

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         flush_all_q      <= 1'b0;
         flush_mstp_q     <= 1'b0;
         flush_dyn_q      <= 1'b0;
         flush_stat_q     <= 1'b0;
         flush_mstp_out_q <= 1'b0;
      end else begin
         flush_all_q      <= wr_one && reg_wdata_in[lecr_pkg::BIT_FLUSH_ALL];
         flush_mstp_q     <= wr_one && reg_wdata_in[lecr_pkg::BIT_FLUSH_MSTP];
         flush_dyn_q      <= flush_go && flush_sel[0];
         flush_stat_q     <= flush_go && flush_sel[1];
         flush_mstp_out_q <= flush_mstp_q && (flush_sel != 2'h0);
      end
   end

   assign flush_dyn_out    = flush_dyn_q;
   assign flush_static_out = flush_stat_q;
   assign flush_mstp_out   = flush_mstp_out_q;

   // ************************************************************
   // Aging time base
   // ************************************************************
   // Period zero yields no aging step; entries then never expire
   wire tick     = (tick_cnt_q == 26'(SEC_CYCLES - 1));
   wire sec_last = (sec_cnt_q + 8'h01 >= age_base_q) && (age_base_q != 8'h00);

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tick_cnt_q <= 26'h0;
         sec_cnt_q  <= 8'h00;
         age_step_q <= 1'b0;
      end else begin
         tick_cnt_q <= tick ? 26'h0 : tick_cnt_q + 26'h1;
         age_step_q <= tick && age_en_q && sec_last;
         if (!age_en_q || wr_age) begin
            sec_cnt_q <= 8'h00;
         end else if (tick) begin
            sec_cnt_q <= sec_last ? 8'h00 : sec_cnt_q + 8'h01;
         end
      end
   end

   assign age_step_out = age_step_q;

   // ************************************************************
   // Forwarding map and priority
   // ************************************************************
   wire filt_en = lookup_in.is_static ? ctrl_two_q[lecr_pkg::BIT_STAT_VFILT]
                                      : ctrl_two_q[lecr_pkg::BIT_DYN_VFILT];
   wire [2:0] hit_map  = filt_en ? (lookup_in.alu_map & lookup_in.vlan_map)
                                 : lookup_in.alu_map;
   wire trap = double_tag_en_in && ctrl_two_q[lecr_pkg::BIT_DT_TRAP]
               && lookup_in.reserved_mcast;
   wire [2:0] map_d = trap ? lecr_pkg::HOST_PORT_MAP : hit_map;

   wire da_hi = lookup_in.da_prio >= lookup_in.sa_prio;
   wire [2:0] prio_d =
      (prio_sel == lecr_pkg::PRIO_FROM_DA) ? lookup_in.da_prio :
      (prio_sel == lecr_pkg::PRIO_FROM_SA) ? lookup_in.sa_prio :
      (prio_sel == lecr_pkg::PRIO_HIGHER)  ? (da_hi ? lookup_in.da_prio : lookup_in.sa_prio)
                                           : (da_hi ? lookup_in.sa_prio : lookup_in.da_prio);

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         fwd_q <= '0;
      end else begin
         fwd_q.valid    <= lookup_in.valid && (lookup_in.hit || trap);
         fwd_q.port_map <= map_d;
         fwd_q.prio     <= prio_d;
      end
   end

   assign fwd_out = fwd_q;

   // ************************************************************
   // Checks
   // ************************************************************
   a_trap_host_only: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      (lookup_in.valid && trap) |=> (fwd_out.port_map == lecr_pkg::HOST_PORT_MAP))
      else $error("trapped frame not sent to host port only");

   a_dyn_vlan_and: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      (lookup_in.valid && !lookup_in.is_static && !trap)
      |=> (fwd_out.port_map == ($past(ctrl_two_q[lecr_pkg::BIT_DYN_VFILT])
          ? ($past(lookup_in.alu_map) & $past(lookup_in.vlan_map)) : $past(lookup_in.alu_map))))
      else $error("dynamic hit map wrong");

   a_stat_vlan_and: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      (lookup_in.valid && lookup_in.is_static && !trap)
      |=> (fwd_out.port_map == ($past(ctrl_two_q[lecr_pkg::BIT_STAT_VFILT])
          ? ($past(lookup_in.alu_map) & $past(lookup_in.vlan_map)) : $past(lookup_in.alu_map))))
      else $error("static hit map wrong");

   a_flush_scope: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      (wr_one && reg_wdata_in[lecr_pkg::BIT_FLUSH_ALL] && !wr_two)
      |-> ##2 ((flush_dyn_out == $past(flush_sel[0], 2))
               && (flush_static_out == $past(flush_sel[1], 2))))
      else $error("flush scope does not follow selection");

   a_flush_none: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      (flush_sel == 2'h0) |=> !flush_dyn_out && !flush_static_out && !flush_mstp_out)
      else $error("flush ran with selection zero");

   a_prio_lower: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      (prio_sel == lecr_pkg::PRIO_LOWER)
      |=> (fwd_out.prio <= $past(lookup_in.da_prio)) && (fwd_out.prio <= $past(lookup_in.sa_prio)))
      else $error("lower priority choice wrong");

   a_prio_higher: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      (prio_sel == lecr_pkg::PRIO_HIGHER)
      |=> (fwd_out.prio >= $past(lookup_in.da_prio)) && (fwd_out.prio >= $past(lookup_in.sa_prio)))
      else $error("higher priority choice wrong");

   a_age_gated: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      age_step_out |-> $past(age_en_q) && $past(tick))
      else $error("aging step without enable or tick");

   a_flush_trigger: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      (flush_dyn_out || flush_static_out) |-> $past(flush_go))
      else $error("flush without trigger");

   a_tick_period: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      tick |=> (tick_cnt_q == 26'h0))
      else $error("second counter did not wrap");

   a_age_count: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      (age_base_q != 8'h00) |-> (sec_cnt_q < age_base_q) || $past(wr_age))
      else $error("seconds count passed age period");

endmodule // lecr_regs

`default_nettype wire

// [logic/lecr_pkg.sv]
/*
 * Constants and carrier types for the lookup engine control registers.
 * Assumes a single 50 MHz system clock and an 8-bit management register port.
 */
`default_nettype none

package lecr_pkg;

   // ************************************************************
   // Register map
   // ************************************************************
   localparam logic [15:0] ADDR_CTRL_ONE = 16'h0311;
   localparam logic [15:0] ADDR_CTRL_TWO = 16'h0312;
   localparam logic [15:0] ADDR_AGE_BASE = 16'h0313;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int BIT_FLUSH_ALL   = 5;
   localparam int BIT_FLUSH_MSTP  = 4;
   localparam int BIT_AGE_EN      = 2;
   localparam int BIT_DT_TRAP     = 6;
   localparam int BIT_DYN_VFILT   = 5;
   localparam int BIT_STAT_VFILT  = 4;
   localparam int FLUSH_SEL_HI    = 3;
   localparam int FLUSH_SEL_LO    = 2;
   localparam int PRIO_SEL_HI     = 1;
   localparam int PRIO_SEL_LO     = 0;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [7:0] RST_CTRL_TWO = 8'h00;
   localparam logic [7:0] RST_AGE_BASE = 8'h4b;
   localparam logic       RST_AGE_EN   = 1'b1;

   // ************************************************************
   // Ports and priority selection
   // ************************************************************
   localparam int         NUM_PORTS     = 3;
   localparam logic [2:0] HOST_PORT_MAP = 3'h4;
   localparam logic [1:0] PRIO_FROM_DA  = 2'h0;
   localparam logic [1:0] PRIO_FROM_SA  = 2'h1;
   localparam logic [1:0] PRIO_HIGHER   = 2'h2;
   localparam logic [1:0] PRIO_LOWER    = 2'h3;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam longint CLK_HZ      = 50_000_000;
   localparam longint AGE_UNIT_S  = 1;
   localparam int     SEC_CYCLES  = int'(AGE_UNIT_S * CLK_HZ);

   typedef struct packed {
      logic       valid;
      logic       hit;
      logic       is_static;
      logic       reserved_mcast;
      logic [2:0] alu_map;
      logic [2:0] vlan_map;
      logic [2:0] da_prio;
      logic [2:0] sa_prio;
   } lecr_lookup_t;

   typedef struct packed {
      logic       valid;
      logic [2:0] port_map;
      logic [2:0] prio;
   } lecr_fwd_t;

endpackage

`default_nettype wire

// [verif/lecr_regs_tb.sv]
/*
 * Self-checking bench for the lookup engine control registers.
 * Assumes the design is driven on falling edges and uses a short second count.
 */
`default_nettype none

module lecr_regs_tb;
   timeunit 1ns;
   timeprecision 1ns;

   // ************************************************************
   // Signals
   // ************************************************************
   localparam int         SEC = 4;
   logic                  clk_sys_in       = 1'b0;
   logic                  rst_n_in         = 1'b0;
   logic [15:0]           reg_addr_in      = 16'h0000;
   logic [7:0]            reg_wdata_in     = 8'h00;
   logic                  reg_wr_in        = 1'b0;
   logic                  reg_rd_in        = 1'b0;
   logic [7:0]            reg_rdata_out;
   logic                  double_tag_en_in = 1'b0;
   lecr_pkg::lecr_lookup_t lookup_in       = '0;
   lecr_pkg::lecr_fwd_t   fwd_out;
   logic                  flush_dyn_out;
   logic                  flush_static_out;
   logic                  flush_mstp_out;
   logic                  age_step_out;
   logic [7:0]            age_period_out;
   int                    num_errors       = 0;
   int                    comparisons      = 0;

   always #10 clk_sys_in = ~clk_sys_in;

   lecr_regs #(.SEC_CYCLES(SEC)) DUT (
      .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
      .reg_rdata_out(reg_rdata_out), .double_tag_en_in(double_tag_en_in),
      .lookup_in(lookup_in), .fwd_out(fwd_out), .flush_dyn_out(flush_dyn_out),
      .flush_static_out(flush_static_out), .flush_mstp_out(flush_mstp_out),
      .age_step_out(age_step_out), .age_period_out(age_period_out));

   // ************************************************************
   // Tasks
   // ************************************************************
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge clk_sys_in);
      reg_addr_in = a;
      reg_wdata_in = d;
      reg_wr_in = 1'b1;
      @(negedge clk_sys_in);
      reg_wr_in = 1'b0;
   endtask

   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      @(negedge clk_sys_in);
      reg_addr_in = a;
      reg_rd_in = 1'b1;
      @(negedge clk_sys_in);
      reg_rd_in = 1'b0;
      chk(reg_rdata_out, exp, "register read");
   endtask

   // Drives one lookup, compares the registered answer one edge later
   task automatic lk(input logic st, rm, ht, input logic [2:0] alu, vl, da, sa,
                     input logic [6:0] exp);
      @(negedge clk_sys_in);
      lookup_in = {1'b1, ht, st, rm, alu, vl, da, sa};
      @(negedge clk_sys_in);
      lookup_in = '0;
      chk({1'b0, fwd_out}, {1'b0, exp}, "forward result");
   endtask

   // Pulses are one cycle wide, so they are gathered over a short span
   task automatic fl(input logic [1:0] sel, input logic [7:0] trig, input logic [2:0] exp,
                     input logic [2:0] mask);
      logic [2:0] seen;
      seen = 3'h0;
      wr(16'h0312, {4'h0, sel, 2'h0});
      wr(16'h0311, trig);
      repeat (3) begin
         @(negedge clk_sys_in);
         seen |= {flush_mstp_out, flush_static_out, flush_dyn_out};
      end
      chk({5'h0, seen & mask}, {5'h0, exp}, "flush pulses");
      rd(16'h0311, trig & 8'h04);
   endtask

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // ************************************************************
   // Tests
   // ************************************************************
   initial begin
      #100us;
      num_errors++;
      $display("mismatch at %0t: watchdog expired", $time);
      conclude();
   end

   initial begin
      int n;
      logic [2:0] da;
      logic [2:0] sa;
      repeat (2) @(negedge clk_sys_in);
      rst_n_in = 1'b1;
      rd(16'h0312, 8'h00);
      rd(16'h0313, 8'h4b);
      chk(age_period_out, 8'h4b, "period copy");
      rd(16'h0311, 8'h04);
      wr(16'h0314, 8'hff);
      rd(16'h0314, 8'h00);
      wr(16'h0312, 8'hff);
      rd(16'h0312, 8'hff);
      $display("test registers done");
      wr(16'h0312, 8'h20);
      lk(1'b0, 1'b0, 1'b1, 3'h7, 3'h3, 3'h0, 3'h0, 7'h58);
      lk(1'b1, 1'b0, 1'b1, 3'h7, 3'h3, 3'h0, 3'h0, 7'h78);
      wr(16'h0312, 8'h10);
      lk(1'b0, 1'b0, 1'b1, 3'h7, 3'h3, 3'h0, 3'h0, 7'h78);
      lk(1'b1, 1'b0, 1'b1, 3'h7, 3'h3, 3'h0, 3'h0, 7'h58);
      // A miss drops valid; the map still follows the table
      lk(1'b0, 1'b0, 1'b0, 3'h7, 3'h3, 3'h0, 3'h0, 7'h38);
      wr(16'h0312, 8'h30);
      lk(1'b0, 1'b0, 1'b1, 3'h7, 3'h3, 3'h0, 3'h0, 7'h58);
      lk(1'b1, 1'b0, 1'b1, 3'h7, 3'h3, 3'h0, 3'h0, 7'h58);
      wr(16'h0312, 8'h40);
      lk(1'b0, 1'b1, 1'b1, 3'h3, 3'h3, 3'h0, 3'h0, 7'h58);
      double_tag_en_in = 1'b1;
      lk(1'b0, 1'b1, 1'b0, 3'h3, 3'h3, 3'h0, 3'h0, 7'h60);
      wr(16'h0312, 8'h00);
      lk(1'b0, 1'b1, 1'b1, 3'h3, 3'h3, 3'h0, 3'h0, 7'h58);
      double_tag_en_in = 1'b0;
      for (int s = 0; s < 8; s++) begin
         da = (s < 4) ? 3'h2 : 3'h6;
         sa = (s < 4) ? 3'h5 : 3'h1;
         wr(16'h0312, {6'h00, 2'(s)});
         lk(1'b0, 1'b0, 1'b1, 3'h1, 3'h7, da, sa, {4'h9,
            (s % 4 == 0) ? da : (s % 4 == 1) ? sa : (s % 4 == 2) ? ((da > sa) ? da : sa) :
            ((da < sa) ? da : sa)});
      end
      $display("test forwarding done");
      for (int s = 0; s < 4; s++)
         fl(2'(s), 8'h24, {1'b0, 2'(s)}, 3'h7);
      fl(2'h3, 8'h14, 3'h7, 3'h7);
      fl(2'h0, 8'h14, 3'h0, 3'h7);
      $display("test flush done");
      wr(16'h0311, 8'h04);
      wr(16'h0313, 8'h02);
      chk(age_period_out, 8'h02, "period copy");
      n = 0;
      while (age_step_out !== 1'b1 && n < 100) begin
         @(negedge clk_sys_in);
         n++;
      end
      n = 0;
      do begin
         @(negedge clk_sys_in);
         n++;
      end while (age_step_out !== 1'b1 && n < 100);
      chk(8'(n), 8'(2 * SEC), "age step spacing");
      wr(16'h0311, 8'h00);
      n = 0;
      repeat (30) begin
         @(negedge clk_sys_in);
         if (age_step_out !== 1'b0) n++;
      end
      chk(8'(n), 8'h00, "aging disabled");
      $display("test aging done");
      // Mid-run reset must restore every field, not just the first power-up
      wr(16'h0312, 8'h7f);
      @(negedge clk_sys_in);
      rst_n_in = 1'b0;
      repeat (2) @(negedge clk_sys_in);
      rst_n_in = 1'b1;
      rd(16'h0312, 8'h00);
      rd(16'h0313, 8'h4b);
      rd(16'h0311, 8'h04);
      $display("test reset done");
      conclude();
   end

endmodule // lecr_regs_tb

`default_nettype wire
